// ---- rtl/vdp_pkg.sv ----
/*
 * Constants for the video decoder picture control block: register
 * byte addresses, field positions, reset values, standards and picture types.
 * Assumes a single 200 MHz clock and byte addresses on the register bus.
 */
package vdp_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] ADDR_STATUS = 24'h900004;
    localparam logic [23:0] ADDR_DEVCFG = 24'h900008;
    localparam logic [23:0] ADDR_CTRL0 = 24'h90000c;
    localparam logic [23:0] ADDR_CTRL1 = 24'h900010;
    localparam logic [23:0] ADDR_CTRL2 = 24'h900014;
    localparam logic [23:0] ADDR_CTRL3 = 24'h900018;
    localparam logic [23:0] ADDR_VECBASE = 24'h9000a8;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ST_RUN = 0;
    localparam int ST_BUF_EMPTY = 14;
    localparam int ST_WDOG = 18;
    localparam int CFG_BYTE_ORDER = 21;
    localparam int CFG_TO_IRQ_EN = 23;
    localparam int C0_STD_LSB = 28;
    localparam int C0_RLC = 27;
    localparam int C0_INTERLACE = 23;
    localparam int C0_STRUCT = 22;
    localparam int C0_BIDIR = 21;
    localparam int C0_TYPE = 20;
    localparam int C0_PARITY = 19;
    localparam int C0_FWD = 18;
    localparam int C0_REF_PARITY = 16;
    localparam int C0_OUT_OFF = 15;
    localparam int C0_DEBLOCK_OFF = 14;
    localparam int C0_FIXED_QP = 13;
    localparam int C0_VEC_EN = 12;
    localparam int C0_REF_FIRST = 11;
    localparam int C0_LOCK = 8;
    localparam int C1_WIDTH_LSB = 23;
    localparam int C1_WOFF_LSB = 19;
    localparam int C1_HEIGHT_LSB = 11;
    localparam int C1_HOFF_LSB = 7;
    localparam int C1_REFS_LSB = 0;
    localparam int C2_QTYPE = 24;
    localparam int C3_LEN_LSB = 0;
    localparam int LEN_W = 25;
    localparam logic [4:0] FULL_MB_PIXELS = 5'h10;
    localparam int TIMEOUT_CYCLES = 262143;

    typedef enum logic [2:0] {
        VDP_STD_H264 = 3'b000,
        VDP_STD_MPEG4 = 3'b001,
        VDP_STD_H263 = 3'b010,
        VDP_STD_JPEG = 3'b011,
        VDP_STD_VC1 = 3'b100,
        VDP_STD_MPEG2 = 3'b101,
        VDP_STD_MPEG1 = 3'b110,
        VDP_STD_RSVD = 3'b111
    } vdp_std_t;

    typedef enum logic [1:0] {
        VDP_PIC_I = 2'b00,
        VDP_PIC_P = 2'b01,
        VDP_PIC_BI = 2'b10,
        VDP_PIC_B = 2'b11
    } vdp_pic_t;
endpackage

// ---- rtl/vdp_bytecnt.sv ----
/*
 * Remaining stream byte counter of the current input buffer.
 * Assumes load and take come from logic on the same clock.
 */
module vdp_bytecnt
    import vdp_pkg::*;
#(
    parameter int W = LEN_W
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic take,
    output logic [W-1:0] remain,
    output logic empty
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } vdp_bc_st_t;

    vdp_bc_st_t st_q;
    vdp_bc_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (load)
        begin
            st_d.cnt = load_val;
        end
        else if (take && st_q.cnt != '0)
        begin
            st_d.cnt = st_q.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign remain = st_q.cnt;
    assign empty = (st_q.cnt == '0);
endmodule

// ---- rtl/vdp_wdog.sv ----
/*
 * Bus inactivity watchdog: pulses expire after LIMIT idle cycles.
 * Assumes activity and hold are synchronous to mclk.
 */
module vdp_wdog
#(
    parameter int LIMIT = 262143
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic arm,
    input wire logic activity,
    input wire logic hold,
    output logic expire
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic fire;
    } vdp_wd_st_t;

    vdp_wd_st_t st_q;
    vdp_wd_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.fire = 1'b0;
        // Any interrupt already pending clears the count to zero
        if (!arm || activity || hold)
        begin
            st_d.cnt = '0;
        end
        else if (st_q.cnt == LAST)
        begin
            st_d.fire = 1'b1;
            st_d.cnt = '0;
        end
        else
        begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign expire = st_q.fire;
endmodule

// ---- rtl/vdp_ctrl.sv ----
/*
 * Picture control register block of the video decoder: Avalon-MM slave,
 * run control, stream buffer accounting, watchdog and decoded settings.
 * Assumes the decoder core shares mclk and gives one-cycle event pulses.
 */
// The Avalon-MM register port was left to the implementer.
module vdp_ctrl
    import vdp_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYCLES
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [vdp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic core_pic_done,
    input wire logic core_stream_error,
    input wire logic core_aso,
    input wire logic core_bus_error,
    input wire logic core_bus_active,
    input wire logic core_bus_req,
    input wire logic core_byte_take,
    input wire logic [31:0] core_stream_word,
    input wire logic core_stream_valid,
    output logic [31:0] stream_word,
    output logic stream_word_valid,
    output logic run_go_bit,
    output logic stream_stall,
    output logic buffer_irq,
    output logic timeout_irq,
    output logic bus_lock,
    output logic input_byte_order,
    output vdp_pkg::vdp_std_t codec_standard_select,
    output logic standard_valid,
    output logic runlength_input_enable,
    output logic current_coding_interlace,
    output logic frame_or_field_structure,
    output vdp_pkg::vdp_pic_t picture_kind,
    output logic current_parity,
    output logic forward_ref_coding,
    output logic backward_ref_coding,
    output logic reference_parity_select,
    output logic reference_parity_used,
    output logic output_write_off,
    output logic deblock_off,
    output logic fixed_qp_select,
    output logic motion_vector_store_enable,
    output logic [31:0] vector_store_base,
    output logic [8:0] width_in_macroblocks,
    output logic [7:0] height_in_macroblocks,
    output logic [4:0] last_col_pixels,
    output logic [4:0] last_row_pixels,
    output logic [4:0] reference_limit,
    output logic inverse_q_method,
    output logic [5:0] init_qp,
    output logic [24:0] buffer_remaining
);
    import vdp_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctrl0;
        logic [31:0] ctrl1;
        logic [31:0] ctrl2;
        logic [31:0] ctrl3;
        logic [31:0] vecbase;
        logic run;
        logic buffer_empty_flag;
        logic watchdog_expired_flag;
        logic byte_order;
        logic timeout_irq_enable;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] sword;
        logic svalid;
    } vdp_ctl_st_t;

    vdp_ctl_st_t st_q;
    vdp_ctl_st_t st_d;

    logic wr_en;
    logic run_start;
    logic load_len;
    logic buf_empty;
    logic wd_expire;
    logic stop_evt;

    function automatic logic [31:0] byte_swap(input logic [31:0] w);
        byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    function automatic logic [4:0] last_pixels(input logic vc1, input logic [3:0] off);
        // Zero offset, or any other standard, means a full macroblock
        if (vc1 && off != 4'h0)
        begin
            last_pixels = {1'b0, off};
        end
        else
        begin
            last_pixels = FULL_MB_PIXELS;
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // One wait cycle: read data are captured, then presented with ack
    assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
    assign wr_en = avs_write && st_q.ack;
    assign stop_evt = core_pic_done || core_stream_error || core_aso || core_bus_error;
    assign run_start = wr_en && avs_address == ADDR_STATUS && avs_writedata[ST_RUN] && !st_q.run;
    assign load_len = run_start || (wr_en && avs_address == ADDR_CTRL3);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.ack = (avs_read || avs_write) && !st_q.ack;
        if ((avs_read || avs_write) && !st_q.ack)
        begin
            st_d.rdata = '0;
            if (avs_address == ADDR_STATUS)
            begin
                st_d.rdata[ST_RUN] = st_q.run;
                st_d.rdata[ST_BUF_EMPTY] = st_q.buffer_empty_flag;
                st_d.rdata[ST_WDOG] = st_q.watchdog_expired_flag;
            end
            else if (avs_address == ADDR_DEVCFG)
            begin
                st_d.rdata[CFG_BYTE_ORDER] = st_q.byte_order;
                st_d.rdata[CFG_TO_IRQ_EN] = st_q.timeout_irq_enable;
            end
            else if (avs_address == ADDR_CTRL0)
            begin
                st_d.rdata = st_q.ctrl0;
            end
            else if (avs_address == ADDR_CTRL1)
            begin
                st_d.rdata = st_q.ctrl1;
            end
            else if (avs_address == ADDR_CTRL2)
            begin
                st_d.rdata = st_q.ctrl2;
            end
            else if (avs_address == ADDR_CTRL3)
            begin
                st_d.rdata = st_q.ctrl3;
            end
            else if (avs_address == ADDR_VECBASE)
            begin
                st_d.rdata = st_q.vecbase;
            end
        end

        // Hardware ends the picture; a start written in the same
        // cycle still takes effect below
        if (stop_evt)
        begin
            st_d.run = 1'b0;
        end

        if (wr_en)
        begin
            if (avs_address == ADDR_STATUS)
            begin
                st_d.run = avs_writedata[ST_RUN];
                if (!avs_writedata[ST_BUF_EMPTY])
                begin
                    st_d.buffer_empty_flag = 1'b0;
                end
                if (!avs_writedata[ST_WDOG])
                begin
                    st_d.watchdog_expired_flag = 1'b0;
                end
            end
            else if (avs_address == ADDR_DEVCFG)
            begin
                st_d.byte_order = avs_writedata[CFG_BYTE_ORDER];
                st_d.timeout_irq_enable = avs_writedata[CFG_TO_IRQ_EN];
            end
            else if (avs_address == ADDR_CTRL0)
            begin
                st_d.ctrl0 = avs_writedata;
            end
            else if (avs_address == ADDR_CTRL1)
            begin
                st_d.ctrl1 = avs_writedata;
            end
            else if (avs_address == ADDR_CTRL2)
            begin
                st_d.ctrl2 = avs_writedata;
            end
            else if (avs_address == ADDR_CTRL3)
            begin
                st_d.ctrl3 = avs_writedata;
            end
            else if (avs_address == ADDR_VECBASE)
            begin
                st_d.vecbase = avs_writedata;
            end
        end

        // Sticky flags: a hardware set wins over a software clear
        if (st_q.run && buf_empty && !core_pic_done && !load_len)
        begin
            st_d.buffer_empty_flag = 1'b1;
        end
        if (wd_expire && st_q.timeout_irq_enable)
        begin
            st_d.watchdog_expired_flag = 1'b1;
        end

        st_d.svalid = core_stream_valid;
        if (core_stream_valid)
        begin
            if (st_q.byte_order)
            begin
                st_d.sword = core_stream_word;
            end
            else
            begin
                st_d.sword = byte_swap(core_stream_word);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Stream buffer and watchdog
    // ----------------------------------------------------------------
    vdp_bytecnt #(
        .W(LEN_W)
    ) u_bytecnt (
        .mclk(mclk),
        .srst(srst),
        .load(load_len),
        .load_val(avs_address == ADDR_CTRL3 ? avs_writedata[LEN_W-1:0]
            : st_q.ctrl3[LEN_W-1:0]),
        .take(core_byte_take && st_q.run),
        .remain(buffer_remaining),
        .empty(buf_empty)
    );

    vdp_wdog #(
        .LIMIT(TIMEOUT)
    ) u_wdog (
        .mclk(mclk),
        .srst(srst),
        .arm(st_q.run && st_q.timeout_irq_enable),
        .activity(core_bus_active),
        .hold(st_q.buffer_empty_flag || st_q.watchdog_expired_flag),
        .expire(wd_expire)
    );

    // ----------------------------------------------------------------
    // Outputs to the bus and the decoder core
    // ----------------------------------------------------------------
    assign avs_readdata = st_q.rdata;
    assign stream_word = st_q.sword;
    assign stream_word_valid = st_q.svalid;
    assign run_go_bit = st_q.run;
    // Core waits for a new buffer while the flag stands
    assign stream_stall = st_q.run && st_q.buffer_empty_flag;
    assign buffer_irq = st_q.buffer_empty_flag;
    assign timeout_irq = st_q.watchdog_expired_flag && st_q.timeout_irq_enable;
    assign bus_lock = st_q.ctrl0[C0_LOCK] && core_bus_req;
    assign input_byte_order = st_q.byte_order;
    assign codec_standard_select = vdp_std_t'(st_q.ctrl0[C0_STD_LSB +: 3]);
    // Top bit of the four-bit field is outside the seven codes
    assign standard_valid = !st_q.ctrl0[31]
        && st_q.ctrl0[C0_STD_LSB +: 3] != VDP_STD_RSVD;
    assign runlength_input_enable = st_q.ctrl0[C0_RLC];
    assign current_coding_interlace = st_q.ctrl0[C0_INTERLACE];
    assign frame_or_field_structure = st_q.ctrl0[C0_STRUCT];
    assign picture_kind = vdp_pic_t'({st_q.ctrl0[C0_BIDIR], st_q.ctrl0[C0_TYPE]});
    assign current_parity = st_q.ctrl0[C0_STRUCT] && st_q.ctrl0[C0_PARITY];
    assign forward_ref_coding = st_q.ctrl0[C0_FWD];
    assign backward_ref_coding = st_q.ctrl0[C0_INTERLACE];
    assign reference_parity_used = (st_q.ctrl1[C1_REFS_LSB +: 5] == 5'h00);
    assign reference_parity_select = reference_parity_used && st_q.ctrl0[C0_REF_PARITY];
    assign output_write_off = st_q.ctrl0[C0_OUT_OFF];
    assign deblock_off = st_q.ctrl0[C0_DEBLOCK_OFF];
    assign fixed_qp_select = st_q.ctrl0[C0_FIXED_QP];
    assign motion_vector_store_enable = st_q.ctrl0[C0_VEC_EN];
    assign vector_store_base = st_q.vecbase;
    assign width_in_macroblocks = st_q.ctrl1[C1_WIDTH_LSB +: 9];
    assign height_in_macroblocks = st_q.ctrl1[C1_HEIGHT_LSB +: 8];
    assign last_col_pixels = last_pixels(codec_standard_select == VDP_STD_VC1,
        st_q.ctrl1[C1_WOFF_LSB +: 4]);
    assign last_row_pixels = last_pixels(codec_standard_select == VDP_STD_VC1,
        st_q.ctrl1[C1_HOFF_LSB +: 4]);
    assign reference_limit = st_q.ctrl1[C1_REFS_LSB +: 5];
    assign inverse_q_method = st_q.ctrl2[C2_QTYPE];
    assign init_qp = st_q.ctrl3[30:25];
endmodule

// ---- tb/vdp_ctrl_sva.sv ----
/*
 * Checker for the picture control block: bus handshake, run control,
 * stream flags, watchdog bound and decoded settings.
 * Assumes it is bound to vdp_ctrl and sees only that module's ports.
 */
module vdp_ctrl_sva
    import vdp_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYCLES
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [vdp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic core_pic_done,
    input wire logic core_bus_active,
    input wire logic core_bus_req,
    input wire logic [31:0] core_stream_word,
    input wire logic core_stream_valid,
    input wire logic [31:0] stream_word,
    input wire logic stream_word_valid,
    input wire logic run_go_bit,
    input wire logic stream_stall,
    input wire logic buffer_irq,
    input wire logic timeout_irq,
    input wire logic bus_lock,
    input wire logic input_byte_order,
    input wire vdp_pkg::vdp_std_t codec_standard_select,
    input wire logic standard_valid,
    input wire logic current_coding_interlace,
    input wire logic frame_or_field_structure,
    input wire logic current_parity,
    input wire logic backward_ref_coding,
    input wire logic reference_parity_select,
    input wire logic reference_parity_used,
    input wire logic [4:0] last_col_pixels,
    input wire logic [4:0] last_row_pixels
);
    logic st_wr;
    logic [31:0] sw_exp;
    logic [31:0] idle_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    assign st_wr = avs_write && !avs_waitrequest && avs_address == ADDR_STATUS;
    assign sw_exp = {core_stream_word[7:0], core_stream_word[15:8],
                     core_stream_word[23:16], core_stream_word[31:24]};

    // Idle running cycles; only a lower bound for the watchdog
    always_ff @(posedge mclk)
        if (srst || core_bus_active || !run_go_bit)
            idle_q <= '0;
        else
            idle_q <= idle_q + 32'h1;

    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest;
    endsequence

    wait_one_a: assert property (s_req |=> s_ack)
        else $error("request not answered after one wait cycle");
    stream_order_a: assert property (core_stream_valid |=> stream_word_valid &&
        stream_word == ($past(input_byte_order) ? $past(core_stream_word) : $past(sw_exp)))
        else $error("stream word byte order wrong");
    run_clear_a: assert property (run_go_bit && core_pic_done && !st_wr |=> !run_go_bit)
        else $error("run bit kept after picture done");
    run_hold_a: assert property (!run_go_bit && !st_wr |=> !run_go_bit)
        else $error("run bit set without software");
    empty_sticky_a: assert property (buffer_irq && !st_wr |=> buffer_irq)
        else $error("buffer empty flag cleared by hardware");
    stall_link_a: assert property (stream_stall == (run_go_bit && buffer_irq))
        else $error("stall does not follow empty flag");
    lock_req_a: assert property (bus_lock |-> core_bus_req)
        else $error("lock without bus request");
    watchdog_bound_a: assert property (
        $rose(timeout_irq) && !$past(avs_write) |-> idle_q >= TIMEOUT - 1)
        else $error("timeout raised too early");
    ref_parity_a: assert property (reference_parity_select |-> reference_parity_used)
        else $error("reference parity used with references");
    field_parity_a: assert property (current_parity |-> frame_or_field_structure)
        else $error("parity set in frame structure");
    back_ref_a: assert property (backward_ref_coding == current_coding_interlace)
        else $error("backward coding differs from current");
    std_rsvd_a: assert property (
        codec_standard_select == VDP_STD_RSVD |-> !standard_valid)
        else $error("reserved standard marked valid");
    offs_vc1_a: assert property (codec_standard_select != VDP_STD_VC1 |->
        last_col_pixels == FULL_MB_PIXELS && last_row_pixels == FULL_MB_PIXELS)
        else $error("offsets applied outside VC-1");
endmodule

bind vdp_ctrl vdp_ctrl_sva #(.TIMEOUT(TIMEOUT)) u_sva (.*);

// ---- tb/vdp_core_model.sv ----
/*
 * Behavioural decoder core facing the control block: consumes stream
 * bytes while running, emits raw stream words and end events.
 * Assumes the bench drives quiet and ev just after rising edges.
 */
module vdp_core_model
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic run_go_bit,
    input wire logic stream_stall,
    input wire logic quiet,
    input wire logic [3:0] ev,
    output logic core_pic_done,
    output logic core_stream_error,
    output logic core_aso,
    output logic core_bus_error,
    output logic core_bus_active,
    output logic core_bus_req,
    output logic core_byte_take,
    output logic [31:0] core_stream_word,
    output logic core_stream_valid
);
    logic [31:0] word_q;

    // Word changes every cycle, so a stale value never looks right
    always_ff @(posedge mclk)
        if (srst)
            word_q <= 32'h0;
        else
            word_q <= word_q + 32'h1357_9bdf;

    assign core_stream_word = word_q;
    assign core_stream_valid = word_q[1];
    // Quiet models a slow core that makes no bus traffic
    assign core_byte_take = run_go_bit && !stream_stall && !quiet;
    assign core_bus_active = core_byte_take;
    assign core_bus_req = run_go_bit && !quiet;
    assign {core_bus_error, core_aso, core_stream_error, core_pic_done} = ev;
endmodule

// ---- tb/tb_vdp_ctrl.sv ----
/*
 * Self-checking bench for the picture control block: register access
 * over Avalon-MM, decoded settings, run control, stream buffer, watchdog.
 * Assumes the package, the design, the core model and the bound checker.
 */
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_vdp_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import vdp_pkg::*;

    localparam int TO = 20;
    localparam int PW = 720;
    localparam int PH = 576;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [23:0] avs_address = 24'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic quiet = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [31:0] q;
    logic [23:0] regs [7] = '{ADDR_STATUS, ADDR_DEVCFG, ADDR_CTRL0, ADDR_CTRL1,
                              ADDR_CTRL2, ADDR_CTRL3, ADDR_VECBASE};
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] avs_readdata, core_stream_word, stream_word, vector_store_base;
    logic avs_waitrequest, core_pic_done, core_stream_error, core_aso, core_bus_error;
    logic core_bus_active, core_bus_req, core_byte_take, core_stream_valid;
    logic stream_word_valid, run_go_bit, stream_stall, buffer_irq, timeout_irq, bus_lock;
    logic input_byte_order, standard_valid, runlength_input_enable, current_coding_interlace;
    logic frame_or_field_structure, current_parity, forward_ref_coding, backward_ref_coding;
    logic reference_parity_select, reference_parity_used, output_write_off, deblock_off;
    logic fixed_qp_select, motion_vector_store_enable, inverse_q_method;
    vdp_std_t codec_standard_select;
    vdp_pic_t picture_kind;
    logic [8:0] width_in_macroblocks;
    logic [7:0] height_in_macroblocks;
    logic [4:0] last_col_pixels, last_row_pixels, reference_limit;
    logic [5:0] init_qp;
    logic [24:0] buffer_remaining;

    vdp_ctrl #(.TIMEOUT(TO)) uut (.*);
    vdp_core_model model (.*);

    always #2.5 mclk = ~mclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            miscompares++;
            test_done();
        end
    end

    // --------------------------------------------------------------
    // Bus access: call just after a rising edge
    // --------------------------------------------------------------
    task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input logic [23:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    task automatic pulse(input int i);
        ev <= 4'h1 << i;
        @(posedge mclk);
        ev <= 4'h0;
        @(posedge mclk);
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        foreach (regs[i])
            rdc(regs[i], RESET_VAL);
        wr(24'h9000fc, 32'hffff_ffff);
        rdc(24'h9000fc, 32'h0);
        for (int s = 0; s < 8; s++)
        begin
            wr(ADDR_CTRL0, {1'b0, 3'(s), 28'h0});
            `CHK(codec_standard_select, vdp_std_t'(s))
            `CHK(standard_valid, s != 7)
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_CTRL0, {10'h0, 2'(k), 20'h0});
            `CHK(picture_kind, vdp_pic_t'(k))
        end
        wr(ADDR_CTRL0, 32'h0008_0000);
        `CHK(current_parity, 1'b0)
        wr(ADDR_CTRL0, 32'h08cd_f100);
        rdc(ADDR_CTRL0, 32'h08cd_f100);
        `CHK({runlength_input_enable, current_coding_interlace}, 2'h3)
        `CHK({frame_or_field_structure, current_parity}, 2'h3)
        `CHK({forward_ref_coding, backward_ref_coding}, 2'h3)
        `CHK({output_write_off, deblock_off}, 2'h3)
        `CHK({fixed_qp_select, motion_vector_store_enable}, 2'h3)
        `CHK({reference_parity_used, reference_parity_select}, 2'h3)
        wr(ADDR_CTRL1, {9'((PW+15)/16), 4'h5, 8'((PH+15)/16), 4'h7, 7'h03});
        `CHK({width_in_macroblocks, height_in_macroblocks}, {9'h2d, 8'h24})
        `CHK({reference_limit, reference_parity_select}, {5'h3, 1'b0})
        `CHK({last_col_pixels, last_row_pixels}, {5'h10, 5'h10})
        wr(ADDR_CTRL0, 32'h48cd_f100);
        `CHK({last_col_pixels, last_row_pixels}, {5'h5, 5'h7})
        wr(ADDR_CTRL1, 32'h0);
        `CHK({last_col_pixels, last_row_pixels}, {5'h10, 5'h10})
        wr(ADDR_CTRL2, 32'h0100_0000);
        `CHK(inverse_q_method, 1'b1)
        wr(ADDR_CTRL2, 32'h0);
        `CHK(inverse_q_method, 1'b0)
        wr(ADDR_VECBASE, 32'h1234_5678);
        `CHK(vector_store_base, 32'h1234_5678)
        wr(ADDR_DEVCFG, 32'h0020_0000);
        `CHK(input_byte_order, 1'b1)
        // Buffer runs dry after five bytes; software refills it
        wr(ADDR_CTRL3, {1'b0, 6'h2a, 25'h5});
        `CHK(init_qp, 6'h2a)
        wr(ADDR_STATUS, 32'h1);
        `CHK(bus_lock, 1'b1)
        for (int i = 0; i < 100 && buffer_irq !== 1'b1; i++)
            @(posedge mclk);
        `CHK({stream_stall, buffer_remaining}, {1'b1, 25'h0})
        rdc(ADDR_STATUS, 32'h0000_4001);
        wr(ADDR_STATUS, 32'h0000_4001);
        `CHK(buffer_irq, 1'b1)
        wr(ADDR_CTRL3, 32'h0000_0100);
        `CHK(buffer_remaining, 25'h100)
        wr(ADDR_STATUS, 32'h1);
        `CHK({buffer_irq, stream_stall}, 2'b00)
        wr(ADDR_DEVCFG, 32'h0);
        for (int e = 0; e < 4; e++)
        begin
            wr(ADDR_STATUS, 32'h1);
            pulse(e);
            `CHK(run_go_bit, 1'b0)
        end
        // Watchdog: silent core, enabled then disabled
        quiet <= 1'b1;
        wr(ADDR_DEVCFG, 32'h0080_0000);
        wr(ADDR_STATUS, 32'h1);
        repeat (TO - 5) @(posedge mclk);
        `CHK(timeout_irq, 1'b0)
        repeat (10) @(posedge mclk);
        `CHK({timeout_irq, run_go_bit}, 2'b11)
        rdc(ADDR_STATUS, 32'h0004_0001);
        wr(ADDR_DEVCFG, 32'h0);
        wr(ADDR_STATUS, 32'h1);
        repeat (TO + 5) @(posedge mclk);
        `CHK(timeout_irq, 1'b0)
        rdc(ADDR_STATUS, 32'h1);
        pulse(0);
        test_done();
    end
endmodule
